// ===== rtl/usm_ir_demod.sv
// Infrared return-to-zero demodulator with reloadable down-counting filter
module usm_ir_demod (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      enable,
  input  wire logic                      rx_fall,
  input  wire logic                      rx_rise,
  input  wire logic [usm_pkg::FILT_W-1:0] filter_len,
  input  wire logic [usm_pkg::DIV_W-1:0] bit_cycles,
  output logic                           rx_demod
);

  usm_pkg::usm_flt_state_t state;
  logic [usm_pkg::FILT_W-1:0] count;
  logic [usm_pkg::DIV_W-1:0]  hold_cnt;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state    <= usm_pkg::FLT_IDLE;
      count    <= usm_pkg::FILT_RESET;
      hold_cnt <= usm_pkg::DIV_RESET;
      rx_demod <= 1'b1;
    end else if (!enable) begin
      state    <= usm_pkg::FLT_IDLE;
      count    <= filter_len;
      rx_demod <= 1'b1;
    end else begin
      case (state)
        usm_pkg::FLT_IDLE: begin
          count    <= filter_len;
          rx_demod <= 1'b1;
          if (rx_fall) begin
            state <= usm_pkg::FLT_RUN;
          end
        end
        usm_pkg::FLT_RUN: begin
          if (rx_rise) begin
            state <= usm_pkg::FLT_IDLE;
            count <= filter_len;
          end else if (count == usm_pkg::FILT_RESET) begin
            state    <= usm_pkg::FLT_HOLD;
            rx_demod <= 1'b0;
            hold_cnt <= bit_cycles;
          end else begin
            count <= count - 8'h01;
          end
        end
        usm_pkg::FLT_HOLD: begin
          // One bit period low, then idle high again
          if (hold_cnt <= 16'h0001) begin
            state    <= usm_pkg::FLT_IDLE;
            rx_demod <= 1'b1;
            count    <= filter_len;
          end else begin
            hold_cnt <= hold_cnt - 16'h0001;
          end
        end
        default: begin
          state    <= usm_pkg::FLT_IDLE;
          rx_demod <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_filter_reload: assert property (@(posedge clk) disable iff (!resetn)
    (enable && state == usm_pkg::FLT_RUN && rx_rise) |=> (count == $past(filter_len)))
    else $error("Filter not reloaded on rising edge");

  a_zero_drives_low: assert property (@(posedge clk) disable iff (!resetn)
    (enable && state == usm_pkg::FLT_RUN && !rx_rise && count == 8'h00) |=> !rx_demod)
    else $error("Expired filter did not drive receiver low");

  a_idle_high: assert property (@(posedge clk) disable iff (!resetn)
    (state == usm_pkg::FLT_IDLE) |-> rx_demod)
    else $error("Demodulator low while idle");

  a_filter_counts: assert property (@(posedge clk) disable iff (!resetn)
    (enable && state == usm_pkg::FLT_RUN && !rx_rise && count != 8'h00)
      |=> (count == $past(count) - 8'h01))
    else $error("Filter did not decrement");

endmodule

// ===== rtl/usm_pkg.sv
// Package: shared constants and carriers for the serial special-mode block
package usm_pkg;

  localparam logic [3:0] MODE_NORMAL    = 4'h0;
  localparam logic [3:0] MODE_RS485     = 4'h1;
  localparam logic [3:0] MODE_IRDA      = 4'h8;
  localparam logic [3:0] MODE_SPI_MST   = 4'hE;
  localparam logic [3:0] MODE_SPI_SLV   = 4'hF;
  localparam logic [1:0] CLKSEL_DIRECT  = 2'h0;
  localparam logic [1:0] CLKSEL_DIV8    = 2'h1;
  localparam logic [1:0] CLKSEL_EXT     = 2'h3;
  localparam int         FILT_W         = 8;
  localparam int         DIV_W          = 16;
  localparam int         CLK_MHZ        = 100;
  localparam logic [7:0] FILT_RESET     = 8'h00;
  localparam logic [15:0] DIV_RESET     = 16'h0000;
  localparam int         PRESCALE_DIV   = 8;
  // Pulse is 3/16 of a bit: numerator and denominator of that fraction
  localparam int         IR_PULSE_NUM   = 3;
  localparam int         IR_PULSE_DEN   = 16;

  typedef struct packed {
    logic [3:0]        mode;
    logic [1:0]        clock_source_select;
    logic              clock_output_enable;
    logic [DIV_W-1:0]  baud_divider;
    logic [FILT_W-1:0] ir_filter_len;
  } usm_cfg_t;

  typedef struct packed {
    logic txd;
    logic sck;
    logic sck_oe;
    logic rts;
  } usm_pins_out_t;

  typedef enum logic [2:0] {
    FLT_IDLE = 3'b001,
    FLT_RUN  = 3'b010,
    FLT_HOLD = 3'b100
  } usm_flt_state_t;

endpackage

// ===== rtl/usm_top.sv
// Special serial modes: infrared, RS485 driver enable and SPI pin mapping
// Overview of operation
// - Infrared filter is an 8-bit down counter loaded with filter length.
// - Falling receive edge starts the filter counting down each clock.
// - Rising edge while counting stops counter and reloads filter length.
// - Counter reaching zero holds receiver input low for one bit.
// - Mode 0x1 selects RS485; framing otherwise unchanged.
// - In RS485 the driver enable is the inverse of transmit done.
// - Driver enable stays high through a programmed timeguard.
// - Mode 0xE is SPI master: MOSI out, MISO in, SCK out, NSS out.
// - Mode 0xF is SPI slave: MOSI in, MISO out, SCK in, NSS in.
// - SPI master has a single slave select output.
// - SPI baud generation works as in synchronous mode.
// - SPI slave always uses external SCK as its bit clock.
// - SPI master toggles SCK one full cycle per bit.
// - Mode 0x8 selects infrared with modulator and demodulator active.
// - Infrared zero bit becomes a pulse of three sixteenths of a bit.
module usm_top (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire usm_pkg::usm_cfg_t cfg,
  input  wire logic              tx_core_data,
  input  wire logic              tx_bit_start,
  input  wire logic              transmit_done_flag,
  input  wire logic              timeguard_active,
  input  wire logic              spi_bit_req,
  input  wire logic              spi_ss_assert,
  input  wire logic              rxd_pin,
  input  wire logic              sck_pin_in,
  input  wire logic              cts_pin,
  output logic                   txd_pin,
  output logic                   sck_pin_out,
  output logic                   sck_pin_oe,
  output logic                   rts_pin,
  output logic                   rx_core_data,
  output logic                   bit_tick,
  output logic                   spi_ss_in_n,
  output logic                   spi_sck_in
);

  logic [2:0] rx_sync;
  logic [2:0] sck_sync;
  logic [2:0] cts_sync;
  logic       rx_level;
  logic       rx_prev;
  logic       rx_fall;
  logic       rx_rise;
  logic       mode_ir;
  logic       mode_mst;
  logic       mode_slv;
  logic       ir_demod;
  logic [usm_pkg::DIV_W-1:0] bit_cycles;
  logic [usm_pkg::DIV_W-1:0] div_cnt;
  logic [2:0]                pre_cnt;
  logic                      pre_tick;
  logic                      sck_phase;
  logic                      spi_active;
  logic [usm_pkg::DIV_W+3:0] ir_cnt;
  logic [usm_pkg::DIV_W+3:0] ir_pulse_len;
  logic [usm_pkg::DIV_W+3:0] ir_bit_len;
  logic                      ir_pulse;

  assign mode_ir  = (cfg.mode == usm_pkg::MODE_IRDA);
  assign mode_mst = (cfg.mode == usm_pkg::MODE_SPI_MST);
  assign mode_slv = (cfg.mode == usm_pkg::MODE_SPI_SLV);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync  <= 3'h7;
      sck_sync <= 3'h0;
      cts_sync <= 3'h7;
      rx_level <= 1'b1;
      rx_prev  <= 1'b1;
    end else begin
      rx_sync  <= {rx_sync[1:0], rxd_pin};
      sck_sync <= {sck_sync[1:0], sck_pin_in};
      cts_sync <= {cts_sync[1:0], cts_pin};
      if (rx_sync[2] == rx_sync[1]) begin
        rx_level <= rx_sync[2];
      end
      rx_prev <= rx_level;
    end
  end

  assign rx_fall = rx_prev && !rx_level;
  assign rx_rise = !rx_prev && rx_level;

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock: synchronous-style divider; slave ignores divider and source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= 3'h0;
    end else begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  assign pre_tick = (cfg.clock_source_select == usm_pkg::CLKSEL_DIV8) ?
                    (pre_cnt == 3'h7) : 1'b1;

  // Cycles per bit in clk units, used for the demodulator hold time
  assign bit_cycles = (cfg.clock_source_select == usm_pkg::CLKSEL_DIV8) ?
                      {cfg.baud_divider[usm_pkg::DIV_W-4:0], 3'h0} : cfg.baud_divider;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt   <= usm_pkg::DIV_RESET;
      sck_phase <= 1'b0;
      bit_tick  <= 1'b0;
      spi_active <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (mode_slv) begin
        // External clock forced; the rising sampled edge marks a bit
        bit_tick   <= sck_sync[2] && !sck_sync[1] ? 1'b0 :
                      (sck_sync[1] && !sck_sync[2]);
        sck_phase  <= 1'b0;
        spi_active <= 1'b0;
        div_cnt    <= usm_pkg::DIV_RESET;
      end else if (pre_tick) begin
        if (div_cnt <= 16'h0001) begin
          div_cnt <= cfg.baud_divider;
        end else begin
          div_cnt <= div_cnt - 16'h0001;
        end
        // Compare fires one count before half way; registered, low half starts at half way, so an even divider splits 50:50
        if (mode_mst && spi_active
            && div_cnt == {1'b0, cfg.baud_divider[usm_pkg::DIV_W-1:1]} + 16'h0001) begin
          sck_phase <= 1'b0;
        end
        if (div_cnt <= 16'h0001) begin
          bit_tick   <= 1'b1;
          spi_active <= mode_mst && spi_bit_req;
          sck_phase  <= mode_mst && spi_bit_req;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared modulator: zero bit becomes a 3/16 bit light pulse
  assign ir_bit_len   = {4'h0, bit_cycles};
  assign ir_pulse_len = 20'((ir_bit_len * 20'(usm_pkg::IR_PULSE_NUM)) /
                        20'(usm_pkg::IR_PULSE_DEN));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_cnt   <= 20'h0_0000;
      ir_pulse <= 1'b0;
    end else if (tx_bit_start && mode_ir && !tx_core_data) begin
      ir_cnt   <= ir_pulse_len;
      ir_pulse <= 1'b1;
    end else if (ir_cnt > 20'h0_0001) begin
      ir_cnt <= ir_cnt - 20'h0_0001;
    end else begin
      ir_cnt   <= 20'h0_0000;
      ir_pulse <= 1'b0;
    end
  end

  usm_ir_demod u_demod (
    .clk        (clk),
    .resetn     (resetn),
    .enable     (mode_ir),
    .rx_fall    (rx_fall),
    .rx_rise    (rx_rise),
    .filter_len (cfg.ir_filter_len),
    .bit_cycles (bit_cycles),
    .rx_demod   (ir_demod)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexing per mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_pin      <= 1'b1;
      rts_pin      <= 1'b0;
      rx_core_data <= 1'b1;
      spi_ss_in_n  <= 1'b1;
    end else begin
      txd_pin      <= mode_ir ? ir_pulse : tx_core_data;
      rx_core_data <= mode_ir ? ir_demod : rx_level;
      if (!mode_slv) begin
        spi_ss_in_n <= 1'b1;
      end else if (cts_sync[2] == cts_sync[1]) begin
        spi_ss_in_n <= cts_sync[2];
      end
      case (cfg.mode)
        usm_pkg::MODE_RS485:   rts_pin <= !transmit_done_flag || timeguard_active;
        // Only one select output exists, so one slave is addressable
        usm_pkg::MODE_SPI_MST: rts_pin <= !spi_ss_assert;
        default:               rts_pin <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_pin_out <= 1'b0;
      sck_pin_oe  <= 1'b0;
      spi_sck_in  <= 1'b0;
    end else begin
      sck_pin_out <= mode_mst ? sck_phase : 1'b0;
      sck_pin_oe  <= mode_mst && cfg.clock_output_enable;
      if (!mode_slv) begin
        spi_sck_in <= 1'b0;
      end else if (sck_sync[2] == sck_sync[1]) begin
        spi_sck_in <= sck_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_rs485_rts: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.mode == usm_pkg::MODE_RS485 && !transmit_done_flag) |=> rts_pin)
    else $error("Driver enable low while transmitting");

  a_rs485_guard: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.mode == usm_pkg::MODE_RS485 && timeguard_active) |=> rts_pin)
    else $error("Driver enable dropped during timeguard");

  a_master_sck_oe: assert property (@(posedge clk) disable iff (!resetn)
    (mode_slv) |=> !sck_pin_oe)
    else $error("SCK driven in slave mode");

  a_ir_pulse_len: assert property (@(posedge clk) disable iff (!resetn)
    (mode_ir && tx_bit_start && !tx_core_data) |=> (ir_cnt == $past(ir_pulse_len)))
    else $error("Infrared pulse length wrong");

endmodule

// ===== verification/tb_top.sv
// Testbench for the serial special-mode block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, tx_core_data, tx_bit_start, transmit_done_flag, timeguard_active;
  logic spi_bit_req, spi_ss_assert, rxd_pin, sck_pin_in, cts_pin;
  logic txd_pin, sck_pin_out, sck_pin_oe, rts_pin, rx_core_data, bit_tick;
  logic spi_ss_in_n, spi_sck_in, win, sck_q;
  usm_pkg::usm_cfg_t cfg;
  int n_mismatch, checks, n_low, n_txh, n_rise, n_tick, n_high;
  ////////////////////////////////////////////////////////////////////////////////
  usm_top u_dut (
    .clk(clk), .resetn(resetn), .cfg(cfg), .tx_core_data(tx_core_data),
    .tx_bit_start(tx_bit_start), .transmit_done_flag(transmit_done_flag),
    .timeguard_active(timeguard_active), .spi_bit_req(spi_bit_req),
    .spi_ss_assert(spi_ss_assert), .rxd_pin(rxd_pin), .sck_pin_in(sck_pin_in),
    .cts_pin(cts_pin), .txd_pin(txd_pin), .sck_pin_out(sck_pin_out),
    .sck_pin_oe(sck_pin_oe), .rts_pin(rts_pin), .rx_core_data(rx_core_data),
    .bit_tick(bit_tick), .spi_ss_in_n(spi_ss_in_n), .spi_sck_in(spi_sck_in)
  );
  usm_peer_model u_peer (
    .clk(clk), .rxd_pin(rxd_pin), .cts_pin(cts_pin), .sck_pin_in(sck_pin_in)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Window counters: cheaper than per-scenario sampling loops
  always @(posedge clk) begin
    sck_q <= sck_pin_out;
    if (win) begin
      n_low  += (rx_core_data === 1'b0);
      n_txh  += (txd_pin === 1'b1);
      n_rise += (sck_pin_out === 1'b1 && sck_q === 1'b0);
      n_tick += (bit_tick === 1'b1);
      n_high += (sck_pin_out === 1'b1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic open_win(input int n);
    n_low = 0;
    n_txh = 0;
    n_rise = 0;
    n_tick = 0;
    n_high = 0;
    win = 1'b1;
    repeat (n) @(negedge clk);
    win = 1'b0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Core reset after an SPI mode change; called at a falling edge
  task automatic core_reset();
    resetn = 1'b0;
    wait_n(2);
    resetn = 1'b1;
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    wait_n(20000);
    n_mismatch++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    cfg = '0;
    tx_core_data = 1'b1;
    tx_bit_start = 1'b0;
    transmit_done_flag = 1'b1;
    timeguard_active = 1'b0;
    spi_bit_req = 1'b0;
    spi_ss_assert = 1'b0;
    win = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(negedge clk);
    chk("rst_pins", {txd_pin, rts_pin, sck_pin_oe, rx_core_data, spi_ss_in_n}, 5'b10011);
    resetn = 1'b1;
    // Infrared: filter length 5, bit of 32 cycles; 10 ns x 5 stays under 1.41 us
    cfg.mode = usm_pkg::MODE_IRDA;
    cfg.clock_source_select = usm_pkg::CLKSEL_DIRECT;
    cfg.baud_divider = 16'h0020;
    cfg.ir_filter_len = 8'h05;
    // Smartcard rate ratio sits outside this block and is taken as nonzero
    wait_n(4);
    fork
      u_peer.ir_pulse(16, 2);
      open_win(100);
    join
    chk("ir_low_len", n_low, 32);
    fork
      u_peer.ir_pulse(3, 2);
      open_win(60);
    join
    chk("ir_glitch", n_low, 0);
    fork
      u_peer.ir_pulse(16, 2);
      open_win(100);
    join
    chk("ir_reload", n_low, 32);
    for (int b = 0; b < 2; b++) begin
      tx_core_data = b[0];
      wait_n(40);
      tx_bit_start = 1'b1;
      fork
        open_win(40);
        begin
          wait_n(1);
          tx_bit_start = 1'b0;
        end
      join
      chk("ir_pulse", n_txh, (b == 0) ? 6 : 0);
    end
    // RS485 driver enable against done flag and timeguard
    cfg.mode = usm_pkg::MODE_RS485;
    for (int k = 0; k < 4; k++) begin
      transmit_done_flag = k[0];
      timeguard_active = k[1];
      wait_n(3);
      chk("rs485_rts", rts_pin, !k[0] || k[1]);
    end
    // SPI master: divider 6, direct then divided by 8
    cfg.mode = usm_pkg::MODE_SPI_MST;
    cfg.clock_output_enable = 1'b1;
    cfg.baud_divider = 16'h0006;
    spi_ss_assert = 1'b1;
    tx_core_data = 1'b0;
    core_reset();
    wait_n(3);
    chk("mst_nss", {rts_pin, sck_pin_oe, txd_pin}, 3'b010);
    tx_core_data = 1'b1;
    wait_n(3);
    chk("mst_mosi", txd_pin, 1'b1);
    spi_bit_req = 1'b1;
    for (int c = 0; c < 2; c++) begin
      cfg.clock_source_select = (c == 0) ? usm_pkg::CLKSEL_DIRECT : usm_pkg::CLKSEL_DIV8;
      wait_n(100);
      open_win((c == 0) ? 60 : 480);
      chk("mst_sck", n_rise, 10);
      chk("mst_bits", n_tick, 10);
      chk("mst_duty", n_high, (c == 0) ? 30 : 240);
    end
    spi_bit_req = 1'b0;
    spi_ss_assert = 1'b0;
    wait_n(3);
    chk("mst_nss_off", rts_pin, 1'b1);
    // SPI slave: pins mapped inwards, divider ignored
    cfg.mode = usm_pkg::MODE_SPI_SLV;
    cfg.clock_source_select = usm_pkg::CLKSEL_DIRECT;
    core_reset();
    u_peer.set_select(1'b0);
    wait_n(8);
    chk("slv_nss", {spi_ss_in_n, sck_pin_oe}, 2'b00);
    fork
      u_peer.spi_clock(4, 10);
      open_win(85);
      begin
        wait_n(17);
        chk("slv_sck_hi", spi_sck_in, 1'b1);
        wait_n(10);
        chk("slv_sck_lo", spi_sck_in, 1'b0);
      end
    join
    chk("slv_ticks", n_tick, 4);
    chk("slv_sck_out", n_high, 0);
    fork
      u_peer.ir_pulse(20, 0);
      begin
        wait_n(12);
        chk("slv_mosi", rx_core_data, 1'b0);
      end
    join
    u_peer.set_select(1'b1);
    wait_n(8);
    chk("slv_nss_off", {spi_ss_in_n, rx_core_data}, 2'b11);
    test_done();
  end
endmodule

// ===== verification/usm_peer_model.sv
// Far-side model: infrared transmitter and external SPI master pins
module usm_peer_model (
  input  wire logic clk,
  output logic      rxd_pin,
  output logic      cts_pin,
  output logic      sck_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle line is high, as an optical receiver with no light shows
  initial begin
    rxd_pin    = 1'b1;
    cts_pin    = 1'b1;
    sck_pin_in = 1'b0;
  end
  // Low pulse of w cycles on the receive pin, then idle for gap cycles
  task automatic ir_pulse(input int w, input int gap);
    @(negedge clk);
    rxd_pin = 1'b0;
    repeat (w) @(negedge clk);
    rxd_pin = 1'b1;
    repeat (gap) @(negedge clk);
  endtask
  // Slave select level from the external master
  task automatic set_select(input logic lvl);
    @(negedge clk);
    cts_pin = lvl;
  endtask
  // Clock stays still outside frames; half period well above three cycles
  task automatic spi_clock(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(negedge clk);
      sck_pin_in = 1'b1;
      repeat (half) @(negedge clk);
      sck_pin_in = 1'b0;
    end
  endtask
endmodule
